// File: verilog/vepid_pkg.sv
package vepid_pkg;

  // register indices, byte address is four times the index
  localparam logic [3:0] VEPID_IDX_EDH_FLAG     = 4'h3;
  localparam logic [3:0] VEPID_IDX_FORMAT       = 4'h4;
  localparam logic [3:0] VEPID_IDX_RESERVED_A_A       = 4'h5;
  localparam logic [3:0] VEPID_IDX_OVERRIDE     = 4'h6;
  localparam logic [3:0] VEPID_IDX_EDH_EXTRACTED_STATUS   = 4'h7;
  localparam logic [3:0] VEPID_IDX_PLACEMENT    = 4'h8;
  localparam logic [3:0] VEPID_IDX_RESERVED_A_B       = 4'h9;
  localparam logic [3:0] VEPID_IDX_LUMA_LOW     = 4'ha;
  localparam logic [3:0] VEPID_IDX_LUMA_HIGH    = 4'hb;
  localparam logic [3:0] VEPID_IDX_CHROMA_LOW   = 4'hc;
  localparam logic [3:0] VEPID_IDX_PROC_CTRL    = 4'hd;
  localparam logic [3:0] VEPID_IDX_IRQ_STATUS   = 4'he;
  localparam logic [3:0] VEPID_IDX_IRQ_MASK     = 4'hf;

  // field positions and widths
  localparam int VEPID_EDH_WR_MSB      = 13;
  localparam int VEPID_EDH_UES_BIT     = 14;
  localparam int VEPID_SCAN_BIT        = 4;
  localparam int VEPID_STANDARD_LOCKED_BIT    = 2;
  localparam int VEPID_V_LOCK_BIT      = 1;
  localparam int VEPID_H_LOCK_BIT      = 0;
  localparam int VEPID_STD_LSB         = 5;
  localparam int VEPID_STD_W           = 5;
  localparam int VEPID_OVR_EN_BIT      = 5;
  localparam int VEPID_FF_V_BIT        = 1;
  localparam int VEPID_AP_V_BIT        = 0;
  localparam int VEPID_EDH_DIS_BIT     = 4;
  localparam int VEPID_PID_DIS_BIT     = 6;
  localparam int VEPID_IRQ_W           = 3;

  // reset values
  localparam logic [15:0] VEPID_RST_ZERO      = 16'h0000;
  localparam logic        VEPID_RST_PLACEMENT = 1'h1;

  // interrupt events: 0 standard lock change, 1 detected standard change, 2 edh crc valid change
  typedef struct packed {
    logic [15:0]            edh_flags;
    logic                   standard_override_enable;
    logic [VEPID_STD_W-1:0] override_standard_code;
    logic                   payload_id_placement_select;
    logic [15:0]            luma_low;
    logic [15:0]            luma_high;
    logic [15:0]            chroma_low;
    logic                   edh_insert_disable;
    logic                   payload_id_insert_disable;
    logic [VEPID_IRQ_W-1:0] irq_status;
    logic [VEPID_IRQ_W-1:0] irq_mask;
  } vepid_ctrl_t;

  typedef struct packed {
    logic [1:0]             lock_sync1;
    logic [1:0]             lock_sync2;
    logic                   standard_locked_sync1;
    logic                   standard_locked_sync2;
    logic                   standard_locked_prev;
    logic                   scan_sync1;
    logic                   scan_sync2;
    logic [VEPID_STD_W-1:0] std_sync1;
    logic [VEPID_STD_W-1:0] std_sync2;
    logic [VEPID_STD_W-1:0] std_prev;
    logic [1:0]             crcv_sync1;
    logic [1:0]             crcv_sync2;
    logic [1:0]             crcv_prev;
    logic                   anc_sync1;
    logic                   anc_sync2;
  } vepid_sense_t;

  typedef struct packed {
    vepid_ctrl_t  ctrl;
    vepid_sense_t sense;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         irq;
    logic [VEPID_STD_W-1:0] active_std;
    logic [15:0]  edh_flags_out;
    logic         edh_insert_enable;
    logic         payload_id_insert_enable;
  } vepid_state_t;

endpackage : vepid_pkg

// File: verilog/vepid_csr.sv
// Overview of operation
// - edh flag word of 16 bits; bits 13..0 writable, 14 and 15 read-only, reset zero
// - format status bit 4 high for interlaced, low for progressive video
// - read-only standard, vertical, horizontal locks in bits 2..0; standard code bits 9..5
// - override bit 5 selects host standard code bits 4..0 over flywheel result
// - placement bit high: first free ancillary space; low: after eav/crc; resets one
// - read-only edh_extracted_status: full-field crc valid bit 1, active-picture bit 0
// - four luma id bytes in two words, even byte high, odd byte low
// - chroma id bytes 2 and 1 in a writable word, byte 2 high, reset zero
// - processing control bit 4 high disables edh crc correction and insertion
// - processing control bit 6 high disables payload id packet insertion
module vepid_csr
  import vepid_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        irq,
  input  wire logic                   h_lock_in,
  input  wire logic                   v_lock_in,
  input  wire logic                   standard_locked_in,
  input  wire logic                   interlaced_in,
  input  wire logic [VEPID_STD_W-1:0] detected_standard_code_in,
  input  wire logic                   full_field_crc_valid_in,
  input  wire logic                   active_picture_crc_valid_in,
  input  wire logic                   anc_unknown_status_flag_in,
  output logic      [VEPID_STD_W-1:0] active_standard_code,
  output logic      [15:0]            edh_flags_out,
  output logic                        edh_insert_enable,
  output logic                        payload_id_insert_enable,
  output logic                        payload_id_placement_select,
  output logic      [15:0]            luma_payload_id_low,
  output logic      [15:0]            luma_payload_id_high,
  output logic      [15:0]            chroma_payload_id_low
);

  vepid_state_t state;
  vepid_state_t next_state;

  // combinational view of the decoded request
  logic                   access;
  logic                   wr_en;
  logic [3:0]             idx;
  logic                   mapped;
  logic [15:0]            rd_word;
  logic [15:0]            wr_word;
  logic [VEPID_IRQ_W-1:0] events;
  logic [VEPID_STD_W-1:0] std_sel;

  always_comb begin
    next_state = state;
    access     = psel && penable && !state.pready;
    idx        = paddr[5:2];
    mapped     = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) && (idx >= VEPID_IDX_EDH_FLAG);
    wr_en      = access && pwrite && mapped;
    // byte lanes merged over current word; only lanes 0 and 1 carry data
    rd_word    = 16'h0000;
    wr_word    = 16'h0000;

    // pins come from the video logic in another domain: two flops before use
    next_state.sense.lock_sync1     = {v_lock_in, h_lock_in};
    next_state.sense.lock_sync2     = state.sense.lock_sync1;
    next_state.sense.standard_locked_sync1 = standard_locked_in;
    next_state.sense.standard_locked_sync2 = state.sense.standard_locked_sync1;
    next_state.sense.standard_locked_prev  = state.sense.standard_locked_sync2;
    next_state.sense.scan_sync1     = interlaced_in;
    next_state.sense.scan_sync2     = state.sense.scan_sync1;
    next_state.sense.std_sync1      = detected_standard_code_in;
    next_state.sense.std_sync2      = state.sense.std_sync1;
    next_state.sense.std_prev       = state.sense.std_sync2;
    next_state.sense.crcv_sync1     = {full_field_crc_valid_in, active_picture_crc_valid_in};
    next_state.sense.crcv_sync2     = state.sense.crcv_sync1;
    next_state.sense.crcv_prev      = state.sense.crcv_sync2;
    next_state.sense.anc_sync1      = anc_unknown_status_flag_in;
    next_state.sense.anc_sync2      = state.sense.anc_sync1;

    // read mux
    case (idx)
      VEPID_IDX_EDH_FLAG: begin
        rd_word = state.ctrl.edh_flags;
      end
      VEPID_IDX_FORMAT: begin
        rd_word[VEPID_STD_LSB +: VEPID_STD_W] = state.sense.std_sync2;
        rd_word[VEPID_SCAN_BIT]               = state.sense.scan_sync2;
        rd_word[VEPID_STANDARD_LOCKED_BIT]           = state.sense.standard_locked_sync2;
        rd_word[VEPID_V_LOCK_BIT]             = state.sense.lock_sync2[1];
        rd_word[VEPID_H_LOCK_BIT]             = state.sense.lock_sync2[0];
      end
      VEPID_IDX_OVERRIDE: begin
        rd_word[VEPID_OVR_EN_BIT]      = state.ctrl.standard_override_enable;
        rd_word[VEPID_STD_W-1:0]       = state.ctrl.override_standard_code;
      end
      VEPID_IDX_EDH_EXTRACTED_STATUS: begin
        rd_word[VEPID_FF_V_BIT] = state.sense.crcv_sync2[1];
        rd_word[VEPID_AP_V_BIT] = state.sense.crcv_sync2[0];
      end
      VEPID_IDX_PLACEMENT: begin
        rd_word[0] = state.ctrl.payload_id_placement_select;
      end
      VEPID_IDX_LUMA_LOW: begin
        rd_word = state.ctrl.luma_low;
      end
      VEPID_IDX_LUMA_HIGH: begin
        rd_word = state.ctrl.luma_high;
      end
      VEPID_IDX_CHROMA_LOW: begin
        rd_word = state.ctrl.chroma_low;
      end
      VEPID_IDX_PROC_CTRL: begin
        rd_word[VEPID_EDH_DIS_BIT] = state.ctrl.edh_insert_disable;
        rd_word[VEPID_PID_DIS_BIT] = state.ctrl.payload_id_insert_disable;
      end
      VEPID_IDX_IRQ_STATUS: begin
        rd_word[VEPID_IRQ_W-1:0] = state.ctrl.irq_status;
      end
      VEPID_IDX_IRQ_MASK: begin
        rd_word[VEPID_IRQ_W-1:0] = state.ctrl.irq_mask;
      end
      default: begin
        rd_word = 16'h0000; // reserved words read zero
      end
    endcase

    wr_word[7:0]  = pstrb[0] ? pwdata[7:0]  : rd_word[7:0];
    wr_word[15:8] = pstrb[1] ? pwdata[15:8] : rd_word[15:8];

    // ues flag is driven from the packet extractor, never from software
    next_state.ctrl.edh_flags[VEPID_EDH_UES_BIT] = state.sense.anc_sync2;
    next_state.ctrl.edh_flags[15]                = 1'h0;

    // register writes
    if (wr_en) begin
      case (idx)
        VEPID_IDX_EDH_FLAG: begin
          next_state.ctrl.edh_flags[VEPID_EDH_WR_MSB:0] = wr_word[VEPID_EDH_WR_MSB:0];
        end
        VEPID_IDX_OVERRIDE: begin
          next_state.ctrl.standard_override_enable = wr_word[VEPID_OVR_EN_BIT];
          next_state.ctrl.override_standard_code   = wr_word[VEPID_STD_W-1:0];
        end
        VEPID_IDX_PLACEMENT: begin
          next_state.ctrl.payload_id_placement_select = wr_word[0];
        end
        VEPID_IDX_LUMA_LOW: begin
          next_state.ctrl.luma_low = wr_word;
        end
        VEPID_IDX_LUMA_HIGH: begin
          next_state.ctrl.luma_high = wr_word;
        end
        VEPID_IDX_CHROMA_LOW: begin
          next_state.ctrl.chroma_low = wr_word;
        end
        VEPID_IDX_PROC_CTRL: begin
          next_state.ctrl.edh_insert_disable        = wr_word[VEPID_EDH_DIS_BIT];
          next_state.ctrl.payload_id_insert_disable = wr_word[VEPID_PID_DIS_BIT];
        end
        VEPID_IDX_IRQ_MASK: begin
          next_state.ctrl.irq_mask = wr_word[VEPID_IRQ_W-1:0];
        end
        default: begin
          next_state.ctrl = next_state.ctrl; // read-only or status handled below
        end
      endcase
    end

    // sticky events; a set in the clearing cycle wins over the write-one clear
    events[0] = state.sense.standard_locked_sync2 != state.sense.standard_locked_prev;
    events[1] = state.sense.std_sync2 != state.sense.std_prev;
    events[2] = |(state.sense.crcv_sync2 ^ state.sense.crcv_prev);
    if (wr_en && idx == VEPID_IDX_IRQ_STATUS) begin
      // a disabled lane clears nothing; the merged word would clear every set bit
      next_state.ctrl.irq_status = state.ctrl.irq_status & ~(pwdata[VEPID_IRQ_W-1:0] & {VEPID_IRQ_W{pstrb[0]}});
    end
    next_state.ctrl.irq_status = next_state.ctrl.irq_status | events;
    next_state.irq = |(next_state.ctrl.irq_status & next_state.ctrl.irq_mask);

    // apb answer: one wait state, registered data
    next_state.pready  = access;
    next_state.pslverr = access && !mapped;
    next_state.prdata  = (access && !pwrite && mapped) ? {16'h0000, rd_word} : 32'h0000_0000;

    // video-side outputs
    std_sel = next_state.ctrl.standard_override_enable ? next_state.ctrl.override_standard_code
                                                       : state.sense.std_sync2;
    next_state.active_std               = std_sel;
    // flags only reach the packet builder while edh insertion is on
    next_state.edh_insert_enable        = !next_state.ctrl.edh_insert_disable;
    next_state.edh_flags_out            = next_state.edh_insert_enable ? next_state.ctrl.edh_flags
                                                                       : 16'h0000;
    next_state.payload_id_insert_enable = !next_state.ctrl.payload_id_insert_disable;
  end

  // single state register; reset to constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state                                  <= '0;
      state.ctrl.edh_flags                   <= VEPID_RST_ZERO;
      state.ctrl.chroma_low                  <= VEPID_RST_ZERO;
      state.ctrl.payload_id_placement_select <= VEPID_RST_PLACEMENT;
      state.edh_insert_enable                <= 1'h1;
      state.payload_id_insert_enable         <= 1'h1;
    end else begin
      state <= next_state;
    end
  end

  assign prdata                      = state.prdata;
  assign pready                      = state.pready;
  assign pslverr                     = state.pslverr;
  assign irq                         = state.irq;
  assign active_standard_code        = state.active_std;
  assign edh_flags_out               = state.edh_flags_out;
  assign edh_insert_enable           = state.edh_insert_enable;
  assign payload_id_insert_enable    = state.payload_id_insert_enable;
  assign payload_id_placement_select = state.ctrl.payload_id_placement_select;
  assign luma_payload_id_low         = state.ctrl.luma_low;
  assign luma_payload_id_high        = state.ctrl.luma_high;
  assign chroma_payload_id_low       = state.ctrl.chroma_low;

endmodule : vepid_csr

// File: tb/vepid_csr_asserts.sv
module vepid_csr_asserts
  import vepid_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        edh_insert_enable,
  input wire logic [15:0] edh_flags_out,
  input wire logic [15:0] luma_payload_id_low
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // the contract fixes one cycle from taken edge to answer
  a_ready_answer: assert property (psel && penable && !pready |=> pready) else $error("no answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_low_idx: assert property (psel && penable && !pready && paddr[5:2] < 4'h3 |=> pslverr)
    else $error("no error on unmapped index");
  a_edh_suppress: assert property (!edh_insert_enable |-> edh_flags_out == 16'h0000)
    else $error("flags leak while disabled");
  a_edh_top_bit: assert property (!edh_flags_out[15]) else $error("flag bit 15 set");
  a_rd_upper_zero: assert property (prdata[31:16] == 16'h0000) else $error("upper read data set");
  a_rd_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  // a word only moves when a write is taken
  a_luma_hold: assert property (!(psel && penable && pwrite) |=> $stable(luma_payload_id_low))
    else $error("luma word changed without write");
  c_err: cover property (pready && pslverr);
  c_write: cover property (pready && pwrite);
  c_disabled: cover property (!edh_insert_enable);
endmodule : vepid_csr_asserts

// File: tb/tb.sv
module tb
  import vepid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, h_l, v_l, s_l, il, ffv, apv, anc;
  logic place, edh_en, pid_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [4:0]  det, act;
  logic [15:0] flags, luma_lo, luma_hi, chroma, rd, w;
  logic [15:0] m [16];
  logic [15:0] e [16];
  integer seed, num_errors, comparisons, cycles, i, k;

  vepid_csr vepid_csr_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .h_lock_in(h_l), .v_lock_in(v_l), .standard_locked_in(s_l), .interlaced_in(il),
    .detected_standard_code_in(det), .full_field_crc_valid_in(ffv), .active_picture_crc_valid_in(apv),
    .anc_unknown_status_flag_in(anc), .active_standard_code(act), .edh_flags_out(flags),
    .edh_insert_enable(edh_en), .payload_id_insert_enable(pid_en), .payload_id_placement_select(place),
    .luma_payload_id_low(luma_lo), .luma_payload_id_high(luma_hi), .chroma_payload_id_low(chroma));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task wrap_up;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task chk(input string n, input logic [15:0] ex, input logic [15:0] got);
    comparisons++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", n, ex, got);
      num_errors++;
    end
  endtask : chk

  // one apb transfer, held until ready is sampled high
  task apb(input logic wr, input int idx, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {6'h00, idx[3:0], 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial begin
    seed = 32'h823b;
    {num_errors, comparisons, cycles} = '0;
    {presetn, psel, penable, pwrite, h_l, v_l, s_l, il, ffv, apv, anc} = '0;
    {paddr, pwdata, det} = '0;
    pstrb = 4'h3;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values of words 3 through 12
    for (i = 3; i < 13; i++) begin
      apb(1'b0, i, 16'h0000);
      chk("reset word", {15'h0, i == 8}, rd);
    end
    // random status and programming, read back through the model
    for (k = 0; k < 4; k++) begin
      {h_l, v_l, s_l, il, ffv, apv, anc} <= 7'($random(seed));
      det <= 5'($random(seed));
      for (i = 3; i < 13; i++) begin
        w = 16'($random(seed));
        apb(1'b1, i, w);
        m[i] = w & (i == 3 ? 16'h3fff : i == 6 ? 16'h003f : i == 8 ? 16'h0001 : i > 9 ? 16'hffff : 16'h0);
      end
      repeat (4) @(posedge pclk);
      e = m;
      e[3] = m[3] | {1'b0, anc, 14'h0};
      e[4] = {6'h00, det, il, 1'b0, s_l, v_l, h_l};
      e[7] = {14'h0, ffv, apv};
      for (i = 3; i < 13; i++) begin
        apb(1'b0, i, 16'h0000);
        chk("word", e[i], rd);
      end
      chk("luma low", e[10], luma_lo);
      chk("luma high", e[11], luma_hi);
      chk("chroma", e[12], chroma);
      chk("placement", {15'h0, e[8][0]}, {15'h0, place});
      chk("standard", {11'h0, e[6][5] ? e[6][4:0] : det}, {11'h0, act});
    end
    // processing control, all four disable combinations
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 13, {9'h0, k[1], 1'b0, k[0], 4'h0});
      repeat (2) @(posedge pclk);
      chk("edh enable", {15'h0, !k[0]}, {15'h0, edh_en});
      chk("pid enable", {15'h0, !k[1]}, {15'h0, pid_en});
      chk("edh flags", k[0] ? 16'h0 : e[3], flags);
    end
    // unmapped index is refused, reserved word reads zero
    apb(1'b1, 0, 16'hffff);
    chk("unmapped error", 16'h1, {15'h0, err});
    apb(1'b0, 5, 16'h0000);
    chk("reserved", 16'h0, {err, rd[14:0]});
    // interrupt: clear, unmask, raise, clear, then masked event
    apb(1'b1, 15, 16'h0000);
    apb(1'b1, 14, 16'h0007);
    apb(1'b1, 15, 16'h0001);
    repeat (2) @(posedge pclk);
    chk("irq idle", 16'h0, {15'h0, irq});
    s_l <= ~s_l;
    repeat (6) @(posedge pclk);
    chk("irq raised", 16'h1, {15'h0, irq});
    apb(1'b0, 14, 16'h0000);
    chk("irq status", 16'h1, rd);
    // clear with lane 0 disabled must leave the status bit set
    pstrb <= 4'h0;
    apb(1'b1, 14, 16'h0007);
    pstrb <= 4'h3;
    chk("irq kept", 16'h1, {15'h0, irq});
    apb(1'b1, 14, 16'h0001);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 16'h0, {15'h0, irq});
    apb(1'b1, 15, 16'h0000);
    s_l <= ~s_l;
    repeat (6) @(posedge pclk);
    chk("irq masked", 16'h0, {15'h0, irq});
    wrap_up();
  end
endmodule : tb

bind vepid_csr vepid_csr_asserts vepid_csr_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .edh_insert_enable(edh_insert_enable), .edh_flags_out(edh_flags_out),
  .luma_payload_id_low(luma_payload_id_low));
